// *** pkg/uvpa_pkg.sv ***
// types shared by the eprom programmer controller
package uvpa_pkg;
    typedef enum logic [1:0] {
        UVPA_CMD_READ = 2'h0,
        UVPA_CMD_PROG = 2'h1,
        UVPA_CMD_IDENT = 2'h2
    } uvpa_cmd_e;
    typedef struct packed {
        uvpa_cmd_e cmd;
        logic [15:0] addr;
        logic [7:0] data;
    } uvpa_req_s;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] id_maker;
        logic [7:0] id_device;
        logic fail;
        logic [4:0] pulses;
    } uvpa_rsp_s;
    typedef struct packed {
        logic [15:0] addr;
        logic id_high_voltage_address_line;
        logic select_and_program_strobe_n;
        logic output_gate_n;
        logic vpp_on;
        logic vcc_prog;
        logic [7:0] byte_lanes_out;
        logic byte_lanes_oe;
    } uvpa_pins_s;
endpackage : uvpa_pkg

// *** pkg/uvpa_regs.svh ***
// timing and field constants for the eprom programmer controller
`ifndef UVPA_REGS_SVH
`define UVPA_REGS_SVH
`define UVPA_CLK_NS 20
`define UVPA_PULSE_US 100
`define UVPA_PULSE_CYC ((`UVPA_PULSE_US * 1000) / `UVPA_CLK_NS)
`define UVPA_MAX_PULSES 25
`define UVPA_SETUP_US 1
`define UVPA_SETUP_CYC ((`UVPA_SETUP_US * 1000 + `UVPA_CLK_NS - 1) / `UVPA_CLK_NS)
`define UVPA_VERIFY_NS 250
`define UVPA_VERIFY_CYC ((`UVPA_VERIFY_NS + `UVPA_CLK_NS - 1) / `UVPA_CLK_NS)
`define UVPA_READ_NS 120
`define UVPA_READ_CYC ((`UVPA_READ_NS + `UVPA_CLK_NS - 1) / `UVPA_CLK_NS)
`define UVPA_FLOAT_NS 30
`define UVPA_FLOAT_CYC ((`UVPA_FLOAT_NS + `UVPA_CLK_NS - 1) / `UVPA_CLK_NS)
`define UVPA_ERASED 8'hFF
`define UVPA_ID_ADDR 16'h0001
`endif

// *** rtl/uvpa_ctrl.sv ***
// programmer / reader controller driving a uv eprom through its pins
`timescale 1ns/1ns
`include "uvpa_regs.svh"
module uvpa_ctrl #(
    parameter int PULSE_CYC = `UVPA_PULSE_CYC,
    parameter int MAX_PULSES = `UVPA_MAX_PULSES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire uvpa_pkg::uvpa_req_s req,
    output logic req_ready,
    output logic rsp_valid,
    output uvpa_pkg::uvpa_rsp_s rsp,
    output uvpa_pkg::uvpa_pins_s pins,
    input wire logic [7:0] byte_lanes_in
);
    import uvpa_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_SETUP = 4'h1,
        ST_RD_WAIT = 4'h2,
        ST_FLOAT = 4'h3,
        ST_PWR_UP = 4'h4,
        ST_PG_SETUP = 4'h5,
        ST_PG_PULSE = 4'h6,
        ST_PG_HOLD = 4'h7,
        ST_VF_WAIT = 4'h8,
        ST_PWR_DN = 4'h9,
        ST_DONE = 4'hA
    } uvpa_st_e;

    uvpa_st_e st;
    uvpa_st_e next_st;
    uvpa_req_s cur;
    uvpa_pins_s next_pins;
    logic [4:0] pulses;
    logic fail;
    logic id_phase;
    logic tmr_load;
    logic [12:0] tmr_count;
    logic tmr_done;
    logic smp_we;
    logic [7:0] smp0;
    logic [7:0] smp1;

    function automatic logic [12:0] cyc(input int n);
        cyc = n[12:0];
    endfunction : cyc

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // a request is taken only while ready is shown, also right after reset
    wire take = req_valid && req_ready;
    wire verify_ok = (byte_lanes_in == cur.data);
    wire give_up = (pulses == MAX_PULSES[4:0]);
    wire is_prog = (cur.cmd == UVPA_CMD_PROG);
    wire is_id = (cur.cmd == UVPA_CMD_IDENT);
    wire [15:0] id_addr = id_phase ? `UVPA_ID_ADDR : 16'h0000;

    uvpa_timer #(.W(13)) u_tmr (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    uvpa_sample u_smp (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .we(smp_we),
        .sel(id_phase),
        .wdata(byte_lanes_in),
        .rdata0(smp0),
        .rdata1(smp1)
    );

    // ----------------------------------------------------------------
    // next state and pin levels
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_pins = pins;
        tmr_load = 1'b0;
        tmr_count = 13'h0000;
        smp_we = 1'b0;
        case (st)
            ST_IDLE: begin
                next_pins.select_and_program_strobe_n = 1'b1;
                next_pins.output_gate_n = 1'b1;
                next_pins.byte_lanes_oe = 1'b0;
                if (take) begin
                    tmr_load = 1'b1;
                    if (req.cmd == UVPA_CMD_PROG) begin
                        next_pins.vcc_prog = 1'b1;
                        tmr_count = cyc(`UVPA_SETUP_CYC);
                        next_st = ST_PWR_UP;
                    end else begin
                        next_pins.addr = (req.cmd == UVPA_CMD_IDENT) ?
                            16'h0000 : req.addr;
                        next_pins.id_high_voltage_address_line =
                            (req.cmd == UVPA_CMD_IDENT);
                        next_pins.select_and_program_strobe_n = 1'b0;
                        next_pins.output_gate_n = 1'b0;
                        tmr_count = cyc(`UVPA_READ_CYC);
                        next_st = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_SETUP: begin
                // second identification byte: code select high
                next_pins.addr = id_addr;
                next_pins.select_and_program_strobe_n = 1'b0;
                next_pins.output_gate_n = 1'b0;
                tmr_load = 1'b1;
                tmr_count = cyc(`UVPA_READ_CYC);
                next_st = ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
                if (tmr_done) begin
                    smp_we = 1'b1;
                    next_pins.output_gate_n = 1'b1;
                    next_pins.select_and_program_strobe_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = cyc(`UVPA_FLOAT_CYC);
                    next_st = ST_FLOAT;
                end
            end
            ST_FLOAT: begin
                if (tmr_done) begin
                    if (is_id && !id_phase) begin
                        next_st = ST_RD_SETUP;
                    end else begin
                        next_pins.id_high_voltage_address_line = 1'b0;
                        next_st = ST_DONE;
                    end
                end
            end
            ST_PWR_UP: begin
                if (tmr_done) begin
                    next_pins.vpp_on = 1'b1;
                    next_pins.addr = cur.addr;
                    next_pins.byte_lanes_out = cur.data;
                    next_pins.byte_lanes_oe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = cyc(`UVPA_SETUP_CYC);
                    next_st = ST_PG_SETUP;
                end
            end
            ST_PG_SETUP: begin
                if (tmr_done) begin
                    next_pins.select_and_program_strobe_n = 1'b0;
                    tmr_load = 1'b1;
                    // timer ends one cycle after its load value
                    tmr_count = cyc(PULSE_CYC - 1);
                    next_st = ST_PG_PULSE;
                end
            end
            ST_PG_PULSE: begin
                if (tmr_done) begin
                    next_pins.select_and_program_strobe_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = cyc(`UVPA_SETUP_CYC);
                    next_st = ST_PG_HOLD;
                end
            end
            ST_PG_HOLD: begin
                // data hold, then drop program voltage and release lanes
                if (tmr_done) begin
                    next_pins.vpp_on = 1'b0;
                    next_pins.byte_lanes_oe = 1'b0;
                    next_pins.output_gate_n = 1'b0;
                    next_pins.select_and_program_strobe_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_count = cyc(`UVPA_VERIFY_CYC);
                    next_st = ST_VF_WAIT;
                end
            end
            ST_VF_WAIT: begin
                if (tmr_done) begin
                    smp_we = 1'b1;
                    next_pins.output_gate_n = 1'b1;
                    next_pins.select_and_program_strobe_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = cyc(`UVPA_SETUP_CYC);
                    if (verify_ok || give_up) begin
                        next_st = ST_PWR_DN;
                    end else begin
                        next_st = ST_PWR_UP;
                    end
                end
            end
            ST_PWR_DN: begin
                if (tmr_done) begin
                    next_pins.vcc_prog = 1'b0;
                    next_st = ST_DONE;
                end
            end
            ST_DONE: begin
                next_st = ST_IDLE;
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_IDLE;
            pins <= '{addr: 16'h0000, id_high_voltage_address_line: 1'b0,
                select_and_program_strobe_n: 1'b1, output_gate_n: 1'b1,
                vpp_on: 1'b0, vcc_prog: 1'b0, byte_lanes_out: 8'h00,
                byte_lanes_oe: 1'b0};
        end else begin
            st <= next_st;
            pins <= next_pins;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
            pulses <= 5'h00;
            fail <= 1'b0;
            id_phase <= 1'b0;
        end else if (st == ST_IDLE && take) begin
            cur <= req;
            pulses <= 5'h00;
            fail <= 1'b0;
            id_phase <= 1'b0;
        end else if (st == ST_FLOAT && tmr_done && is_id) begin
            id_phase <= 1'b1;
        end else if (st == ST_PG_SETUP && tmr_done) begin
            pulses <= pulses + 5'h01;
        end else if (st == ST_VF_WAIT && tmr_done) begin
            fail <= !verify_ok && give_up;
        end
    end

    // ----------------------------------------------------------------
    // response
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            req_ready <= (next_st == ST_IDLE);
            rsp_valid <= (st == ST_DONE);
            if (st == ST_DONE) begin
                rsp.data <= smp0;
                rsp.id_maker <= is_id ? smp0 : 8'h00;
                rsp.id_device <= is_id ? smp1 : 8'h00;
                rsp.fail <= fail;
                rsp.pulses <= pulses;
            end
        end
    end
endmodule : uvpa_ctrl

// *** rtl/uvpa_sample.sv ***
// capture register for data read back from the byte lanes
`timescale 1ns/1ns
module uvpa_sample (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic sel,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata0,
    output logic [7:0] rdata1
);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata0 <= 8'h00;
            rdata1 <= 8'h00;
        end else if (we && !sel) begin
            rdata0 <= wdata;
        end else if (we && sel) begin
            rdata1 <= wdata;
        end
    end
endmodule : uvpa_sample

// *** rtl/uvpa_timer.sv ***
// down counter for pin timing
`timescale 1ns/1ns
module uvpa_timer #(
    parameter int W = 13
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt;
    assign done = (cnt == '0);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= count;
        end else if (!done) begin
            cnt <= cnt - 1'b1;
        end
    end
endmodule : uvpa_timer

// *** verif/tb.sv ***
// self-checking bench for the eprom programmer controller
`timescale 1ns/1ns
module tb;
    import uvpa_pkg::*;
    localparam int PULSE_CYC = 20;
    localparam int MAX_PULSES = 25;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b1;
    logic req_valid = 1'b0;
    uvpa_req_s req = '0;
    logic req_ready, rsp_valid, dev_drive;
    uvpa_rsp_s rsp;
    uvpa_pins_s pins;
    logic [7:0] lanes, dev_dout;
    logic [7:0] last_lanes = 8'h00;
    logic [4:0] need = 5'h1;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #10 sys_clk = ~sys_clk;
    // a released lane shows a changing pattern, not the old value
    assign lanes = pins.byte_lanes_oe ? pins.byte_lanes_out
        : dev_drive ? dev_dout : ~last_lanes;
    always @(posedge sys_clk) last_lanes <= lanes;
    uvpa_ctrl #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .pins(pins), .byte_lanes_in(lanes));
    uvpa_eprom_model dev (.sys_clk(sys_clk), .pins(pins), .lanes(lanes),
        .need(need), .drive(dev_drive), .dout(dev_dout));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check
    task automatic do_cmd(input uvpa_cmd_e c, input logic [15:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        req = '{cmd: c, addr: a, data: d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check({7'h0, rsp_valid}, 8'h01, "response");
    endtask : do_cmd
    task automatic t_reset();
        check({7'h0, req_ready}, 8'h00, "ready in reset");
        check({7'h0, pins.select_and_program_strobe_n}, 8'h01, "strobe");
        check({6'h0, pins.vpp_on, pins.vcc_prog}, 8'h00, "supplies");
        arst_n = 1'b1;
        @(negedge sys_clk);
        check({7'h0, req_ready}, 8'h01, "ready after reset");
        $display("test reset done");
    endtask : t_reset
    task automatic t_read_erased();
        do_cmd(UVPA_CMD_READ, 16'h0100, 8'h00);
        check(rsp.data, 8'hFF, "erased byte");
        $display("test read erased done");
    endtask : t_read_erased
    task automatic t_program_once();
        need = 5'h1;
        do_cmd(UVPA_CMD_PROG, 16'h1234, 8'h5A);
        check({7'h0, rsp.fail}, 8'h00, "fail");
        check(8'(rsp.pulses), 8'h01, "pulses");
        do_cmd(UVPA_CMD_READ, 16'h1234, 8'h00);
        check(rsp.data, 8'h5A, "programmed byte");
        $display("test program once done");
    endtask : t_program_once
    task automatic t_program_slow();
        need = 5'h3;
        do_cmd(UVPA_CMD_PROG, 16'h2000, 8'hC3);
        check({7'h0, rsp.fail}, 8'h00, "fail slow");
        check(8'(rsp.pulses), 8'h03, "pulses slow");
        $display("test program slow done");
    endtask : t_program_slow
    task automatic t_no_ones();
        need = 5'h1;
        do_cmd(UVPA_CMD_PROG, 16'h1234, 8'hF0);
        check({7'h0, rsp.fail}, 8'h01, "fail set");
        check(8'(rsp.pulses), 8'h19, "pulse limit");
        do_cmd(UVPA_CMD_READ, 16'h1234, 8'h00);
        check(rsp.data, 8'h50, "zeros kept");
        $display("test no ones done");
    endtask : t_no_ones
    task automatic t_ident();
        do_cmd(UVPA_CMD_IDENT, 16'h0000, 8'h00);
        check(rsp.id_maker, dev.MAKER_CODE, "maker code");
        check(rsp.id_device, dev.DEVICE_CODE, "device code");
        $display("test ident done");
    endtask : t_ident
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        // a real falling edge so the asynchronous resets take hold
        arst_n = 1'b0;
        repeat (12) @(negedge sys_clk);
        t_reset();
        t_read_erased();
        t_program_once();
        t_program_slow();
        t_no_ones();
        t_ident();
        report_and_stop();
    end
endmodule : tb
bind uvpa_ctrl uvpa_ctrl_assertions #(.PULSE_CYC(PULSE_CYC),
    .MAX_PULSES(MAX_PULSES)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .byte_lanes_in(byte_lanes_in));

// *** verif/uvpa_ctrl_assertions.sv ***
// concurrent checks on the pins and handshake of the programmer controller
`timescale 1ns/1ns
module uvpa_ctrl_assertions #(
    parameter int PULSE_CYC = 5000,
    parameter int MAX_PULSES = 25
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire uvpa_pkg::uvpa_req_s req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire uvpa_pkg::uvpa_rsp_s rsp,
    input wire uvpa_pkg::uvpa_pins_s pins,
    input wire logic [7:0] byte_lanes_in
);
    import uvpa_pkg::*;
    int low_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // length of the current program strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) low_cnt <= 0;
        else low_cnt <= (pins.vpp_on && !pins.select_and_program_strobe_n)
            ? low_cnt + 1 : 0;
    end
    property p_vcc_first; pins.vpp_on |-> pins.vcc_prog; endproperty
    a_vcc_first: assert property (p_vcc_first) else $error("vpp without vcc");
    property p_vcc_last;
        $fell(pins.vcc_prog) |-> !pins.vpp_on && $past(!pins.vpp_on);
    endproperty
    a_vcc_last: assert property (p_vcc_last) else $error("vcc off early");
    property p_pulse;
        $rose(pins.select_and_program_strobe_n) && pins.vpp_on
            |-> low_cnt == PULSE_CYC;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse width");
    property p_data_held;
        pins.vpp_on && !pins.select_and_program_strobe_n |-> pins.byte_lanes_oe
            && $stable(pins.byte_lanes_out) && $stable(pins.addr);
    endproperty
    a_data_held: assert property (p_data_held) else $error("lanes moved");
    property p_no_clash;
        !pins.output_gate_n && !pins.vpp_on |-> !pins.byte_lanes_oe;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("lane clash");
    property p_access;
        $fell(pins.output_gate_n) && !pins.vpp_on |->
            (!pins.output_gate_n && !pins.select_and_program_strobe_n)[*6];
    endproperty
    a_access: assert property (p_access) else $error("access cut");
    property p_id;
        pins.id_high_voltage_address_line |->
            pins.addr[15:1] == 15'h0 && !pins.vpp_on && !pins.vcc_prog;
    endproperty
    a_id: assert property (p_id) else $error("id mode pins");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_done;
        rsp_valid |-> pins.select_and_program_strobe_n && !pins.vcc_prog
            && rsp.pulses <= MAX_PULSES && (!rsp.fail || rsp.pulses == MAX_PULSES);
    endproperty
    a_done: assert property (p_done) else $error("end state");
endmodule : uvpa_ctrl_assertions

// *** verif/uvpa_eprom_model.sv ***
// behavioural model of the eprom on the controller's pins
`timescale 1ns/1ns
module uvpa_eprom_model #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3C, // arbitrary value
    parameter int ACC_CYC = 4
) (
    input wire logic sys_clk,
    input wire uvpa_pkg::uvpa_pins_s pins,
    input wire logic [7:0] lanes,
    input wire logic [4:0] need,
    output logic drive,
    output logic [7:0] dout
);
    import uvpa_pkg::*;
    logic [7:0] mem [0:65535];
    int acc = 0;
    logic [4:0] hits = 5'h0;
    logic [15:0] last_addr = 16'hFFFF;
    logic prev_n = 1'b1;
    wire logic id_mode = pins.id_high_voltage_address_line
        && pins.addr[15:1] == 15'h0;
    wire logic [7:0] code = pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
    wire logic [7:0] word = id_mode ? code : mem[pins.addr];
    wire logic [4:0] next_hits = pins.addr == last_addr ? hits + 5'h1 : 5'h1;
    wire logic pulse_end = pins.vpp_on && !prev_n
        && pins.select_and_program_strobe_n;
    assign drive = !pins.select_and_program_strobe_n && !pins.output_gate_n
        && !pins.vpp_on;
    assign dout = acc >= ACC_CYC ? word : ~word;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    always @(posedge sys_clk) begin
        acc <= drive ? acc + 1 : 0;
        prev_n <= pins.select_and_program_strobe_n;
        if (pulse_end) begin
            hits <= next_hits;
            last_addr <= pins.addr;
            if (need != 5'h0 && next_hits >= need)
                mem[pins.addr] <= mem[pins.addr] & lanes;
        end
    end
endmodule : uvpa_eprom_model
